// [eeac_pkg.sv]
package eeac_pkg;

  // data memory geometry
  localparam int NV_DEPTH   = 32;
  localparam int NV_ADDR_W  = 5;
  localparam int NV_DATA_W  = 8;

  // own register offsets (byte addresses, one aligned word each)
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_ADDR   = 8'h04;
  localparam logic [7:0] OFS_WDATA  = 8'h08;
  localparam logic [7:0] OFS_RDATA  = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;

  // control register fields
  localparam int CTRL_READ_BIT   = 0;
  localparam int CTRL_WRITE_BIT  = 1;
  localparam int CTRL_IEN_BIT    = 2;
  localparam int CTRL_SLEEP_BIT  = 3;
  localparam int CTRL_IRQCFG_BIT = 4;

  // status register fields
  localparam int ST_BUSY_BIT    = 0;
  localparam int ST_DONE_BIT    = 1;
  localparam int ST_REFUSED_BIT = 2;

  // reset values
  localparam logic [NV_ADDR_W-1:0] ADDR_RESET  = 5'h00;
  localparam logic [NV_DATA_W-1:0] DATA_RESET  = 8'h00;
  localparam logic [3:0]           IDX_RESET   = 4'h0;

  // device special function register addresses
  localparam logic [7:0] DEV_INDIRECT_ACCESS_REG_ADDR = 8'h02;
  localparam logic [7:0] DEV_MP1_ADDR  = 8'h03;
  localparam logic [7:0] DEV_BP_ADDR   = 8'h04;
  localparam logic [7:0] DEV_INTC_ADDR = 8'h0b;
  localparam logic [7:0] DEV_EEA_ADDR  = 8'h1e;
  localparam logic [7:0] DEV_EED_ADDR  = 8'h1f;

  // pointer values that open and close the bank holding the control register
  localparam logic [7:0] MP1_CTRL_VALUE = 8'h40;
  localparam logic [7:0] BP_BANK1       = 8'h01;
  localparam logic [7:0] BP_BANK0       = 8'h00;

  // device control register values
  localparam logic [7:0] CTL_CLEAR   = 8'h00;
  localparam logic [7:0] CTL_WPERMIT = 8'h08;
  localparam logic [7:0] CTL_WSTART  = 8'h04;
  localparam logic [7:0] CTL_RPERMIT = 8'h02;
  localparam logic [7:0] CTL_RSTART  = 8'h01;

  // device interrupt control register fields
  localparam int INTC_GLOBAL_BIT = 0;
  localparam int INTC_EEPROM_BIT = 1;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } eeac_apb_req_type;

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } eeac_apb_rsp_type;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } eeac_dev_req_type;

  typedef enum logic [1:0] {EEAC_STEP_PUT, EEAC_STEP_POLL, EEAC_STEP_FETCH} eeac_step_kind_type;

  typedef struct packed {
    eeac_dev_req_type   req;
    eeac_step_kind_type kind;
    logic               last;
  } eeac_step_type;

  typedef enum logic [1:0] {EEAC_OP_READ, EEAC_OP_WRITE, EEAC_OP_IRQCFG} eeac_op_type;
  typedef enum logic [1:0] {EEAC_ST_IDLE, EEAC_ST_ISSUE, EEAC_ST_WAIT, EEAC_ST_SAMPLE} eeac_state_type;
  typedef enum logic [2:0] {
    EEAC_REG_CTRL, EEAC_REG_ADDR, EEAC_REG_WDATA, EEAC_REG_RDATA, EEAC_REG_STATUS, EEAC_REG_NONE
  } eeac_reg_sel_type;

endpackage : eeac_pkg

// [eeac_ctrl.sv]
module eeac_ctrl (
  input  wire logic                       clock,
  input  wire logic                       rst,
  input  wire eeac_pkg::eeac_apb_req_type apb_req,
  output eeac_pkg::eeac_apb_rsp_type      apb_rsp,
  output eeac_pkg::eeac_dev_req_type      dev_req,
  input  wire logic [7:0]                 dev_rdata,
  output logic                            sleep_req
);
  import eeac_pkg::*;

  function automatic eeac_reg_sel_type dec_fn(input logic [31:0] paddr);
    eeac_reg_sel_type sel;
    sel = EEAC_REG_NONE;
    if (paddr[31:8] == 24'h000000) begin
      unique case (paddr[7:0])
        OFS_CTRL:   sel = EEAC_REG_CTRL;
        OFS_ADDR:   sel = EEAC_REG_ADDR;
        OFS_WDATA:  sel = EEAC_REG_WDATA;
        OFS_RDATA:  sel = EEAC_REG_RDATA;
        OFS_STATUS: sel = EEAC_REG_STATUS;
        default:    sel = EEAC_REG_NONE;
      endcase
    end
    return sel;
  endfunction : dec_fn

  function automatic eeac_step_type put_fn(input logic [7:0] addr, input logic [7:0] data, input logic last);
    eeac_step_type s;
    s.req  = '{valid: 1'b1, write: 1'b1, addr: addr, wdata: data};
    s.kind = EEAC_STEP_PUT;
    s.last = last;
    return s;
  endfunction : put_fn

  function automatic eeac_step_type get_fn(input logic [7:0] addr, input eeac_step_kind_type kind,
                                           input logic last);
    eeac_step_type s;
    s.req  = '{valid: 1'b1, write: 1'b0, addr: addr, wdata: 8'h00};
    s.kind = kind;
    s.last = last;
    return s;
  endfunction : get_fn

  // whole-byte write: other bits of the device interrupt register are cleared
  function automatic logic [7:0] intc_fn(input logic ien, input logic glob);
    logic [7:0] v;
    v = 8'h00;
    v[INTC_EEPROM_BIT] = ien;
    v[INTC_GLOBAL_BIT] = glob;
    return v;
  endfunction : intc_fn

  function automatic eeac_step_type step_fn(input eeac_op_type op, input logic [3:0] idx,
                                            input logic [NV_ADDR_W-1:0] a, input logic [NV_DATA_W-1:0] d,
                                            input logic ien);
    eeac_step_type s;
    s = put_fn(DEV_BP_ADDR, BP_BANK0, 1'b1);
    unique case (op)
      EEAC_OP_WRITE: begin
        unique case (idx)
          4'h0: s = put_fn(DEV_EEA_ADDR, {3'h0, a}, 1'b0);
          4'h1: s = put_fn(DEV_EED_ADDR, d, 1'b0);
          4'h2: s = put_fn(DEV_MP1_ADDR, MP1_CTRL_VALUE, 1'b0);
          4'h3: s = put_fn(DEV_BP_ADDR, BP_BANK1, 1'b0);
          4'h4: s = put_fn(DEV_INTC_ADDR, intc_fn(ien, 1'b0), 1'b0);
          4'h5: s = put_fn(DEV_INDIRECT_ACCESS_REG_ADDR, CTL_WPERMIT, 1'b0);
          4'h6: s = put_fn(DEV_INDIRECT_ACCESS_REG_ADDR, CTL_WPERMIT | CTL_WSTART, 1'b0);
          4'h7: s = put_fn(DEV_INTC_ADDR, intc_fn(ien, 1'b1), 1'b0);
          4'h8: s = get_fn(DEV_INDIRECT_ACCESS_REG_ADDR, EEAC_STEP_POLL, 1'b0);
          4'h9: s = put_fn(DEV_INDIRECT_ACCESS_REG_ADDR, CTL_CLEAR, 1'b0);
          4'ha: s = put_fn(DEV_BP_ADDR, BP_BANK0, 1'b1);
          default: s = put_fn(DEV_BP_ADDR, BP_BANK0, 1'b1);
        endcase
      end
      EEAC_OP_READ: begin
        unique case (idx)
          4'h0: s = put_fn(DEV_EEA_ADDR, {3'h0, a}, 1'b0);
          4'h1: s = put_fn(DEV_MP1_ADDR, MP1_CTRL_VALUE, 1'b0);
          4'h2: s = put_fn(DEV_BP_ADDR, BP_BANK1, 1'b0);
          4'h3: s = put_fn(DEV_INDIRECT_ACCESS_REG_ADDR, CTL_RPERMIT, 1'b0);
          4'h4: s = put_fn(DEV_INDIRECT_ACCESS_REG_ADDR, CTL_RPERMIT | CTL_RSTART, 1'b0);
          4'h5: s = get_fn(DEV_INDIRECT_ACCESS_REG_ADDR, EEAC_STEP_POLL, 1'b0);
          4'h6: s = put_fn(DEV_INDIRECT_ACCESS_REG_ADDR, CTL_CLEAR, 1'b0);
          4'h7: s = put_fn(DEV_BP_ADDR, BP_BANK0, 1'b0);
          4'h8: s = get_fn(DEV_EED_ADDR, EEAC_STEP_FETCH, 1'b1);
          default: s = put_fn(DEV_BP_ADDR, BP_BANK0, 1'b1);
        endcase
      end
      EEAC_OP_IRQCFG: s = put_fn(DEV_INTC_ADDR, intc_fn(ien, 1'b1), 1'b1);
      default: s = put_fn(DEV_BP_ADDR, BP_BANK0, 1'b1);
    endcase
    return s;
  endfunction : step_fn

  // register group
  eeac_apb_rsp_type       apb_rsp_reg,  apb_rsp_next;
  logic [NV_ADDR_W-1:0]   addr_reg,     addr_next;
  logic [NV_DATA_W-1:0]   wdata_reg,    wdata_next;
  logic [NV_DATA_W-1:0]   rdata_reg,    rdata_next;
  logic                   ien_reg,      ien_next;
  logic                   sleep_bit_reg, sleep_bit_next;
  logic                   done_reg,     done_next;
  logic                   refused_reg,  refused_next;
  logic                   sleep_req_reg, sleep_req_next;

  // sequencer group
  eeac_state_type         st_reg,       st_next;
  eeac_op_type            op_reg,       op_next;
  logic [3:0]             idx_reg,      idx_next;
  eeac_dev_req_type       dev_req_reg,  dev_req_next;

  logic                   start_cmd;
  eeac_op_type            start_op;
  logic                   done_set;
  logic [NV_DATA_W-1:0]   fetch_data;
  logic                   fetch_set;

  eeac_reg_sel_type       sel;
  logic                   fire;
  logic                   busy;
  logic [31:0]            rd_word;
  logic [7:0]             poll_mask;
  eeac_step_type          cur;

  assign apb_rsp   = apb_rsp_reg;
  assign dev_req   = dev_req_reg;
  assign sleep_req = sleep_req_reg;

  always_comb begin
    sel   = dec_fn(apb_req.paddr);
    fire  = apb_req.psel & apb_req.penable & apb_rsp_reg.pready;
    busy  = (st_reg != EEAC_ST_IDLE);
    unique case (sel)
      EEAC_REG_CTRL:   rd_word = {27'h0, 1'b0, sleep_bit_reg, ien_reg, 2'b00};
      EEAC_REG_ADDR:   rd_word = {27'h0, addr_reg};
      EEAC_REG_WDATA:  rd_word = {24'h0, wdata_reg};
      EEAC_REG_RDATA:  rd_word = {24'h0, rdata_reg};
      EEAC_REG_STATUS: rd_word = {29'h0, refused_reg, done_reg, busy};
      default:         rd_word = 32'h0;
    endcase
    apb_rsp_next.pready  = apb_req.psel & apb_req.penable & ~apb_rsp_reg.pready;
    apb_rsp_next.prdata  = apb_rsp_next.pready ? rd_word : 32'h0;
    apb_rsp_next.pslverr = apb_rsp_next.pready & (sel == EEAC_REG_NONE);
    addr_next      = addr_reg;
    wdata_next     = wdata_reg;
    ien_next       = ien_reg;
    sleep_bit_next = sleep_bit_reg;
    done_next      = done_reg;
    refused_next   = refused_reg;
    start_cmd      = 1'b0;
    start_op       = EEAC_OP_READ;
    if (fire & apb_req.pwrite) begin
      unique case (sel)
        EEAC_REG_CTRL: begin
          ien_next       = apb_req.pwdata[CTRL_IEN_BIT];
          sleep_bit_next = apb_req.pwdata[CTRL_SLEEP_BIT];
          if (apb_req.pwdata[CTRL_WRITE_BIT]) begin
            start_op = EEAC_OP_WRITE;
          end else if (apb_req.pwdata[CTRL_READ_BIT]) begin
            start_op = EEAC_OP_READ;
          end else begin
            start_op = EEAC_OP_IRQCFG;
          end
          if (apb_req.pwdata[CTRL_WRITE_BIT] | apb_req.pwdata[CTRL_READ_BIT] |
              apb_req.pwdata[CTRL_IRQCFG_BIT]) begin
            // a sleep request pending or active blocks new operations
            if (busy | sleep_bit_next | sleep_req_reg) begin
              refused_next = 1'b1;
            end else begin
              start_cmd = 1'b1;
            end
          end
        end
        EEAC_REG_ADDR: begin
          if (busy) refused_next = 1'b1;
          else addr_next = apb_req.pwdata[NV_ADDR_W-1:0];
        end
        EEAC_REG_WDATA: begin
          if (busy) refused_next = 1'b1;
          else wdata_next = apb_req.pwdata[NV_DATA_W-1:0];
        end
        EEAC_REG_STATUS: begin
          if (apb_req.pwdata[ST_DONE_BIT]) done_next = 1'b0;
          if (apb_req.pwdata[ST_REFUSED_BIT]) refused_next = 1'b0;
        end
        default: begin
        end
      endcase
    end
    // hardware set wins over the write-one clear
    if (done_set) done_next = 1'b1;
    rdata_next = fetch_set ? fetch_data : rdata_reg;
    // low-power request waits one idle cycle so the last device access has gone out first
    sleep_req_next = sleep_bit_next & ~busy & (st_next == EEAC_ST_IDLE) & ~start_cmd;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      apb_rsp_reg   <= '0;
      addr_reg      <= ADDR_RESET;
      wdata_reg     <= DATA_RESET;
      rdata_reg     <= DATA_RESET;
      ien_reg       <= 1'b0;
      sleep_bit_reg <= 1'b0;
      done_reg      <= 1'b0;
      refused_reg   <= 1'b0;
      sleep_req_reg <= 1'b0;
    end else begin
      apb_rsp_reg   <= apb_rsp_next;
      addr_reg      <= addr_next;
      wdata_reg     <= wdata_next;
      rdata_reg     <= rdata_next;
      ien_reg       <= ien_next;
      sleep_bit_reg <= sleep_bit_next;
      done_reg      <= done_next;
      refused_reg   <= refused_next;
      sleep_req_reg <= sleep_req_next;
    end
  end

  always_comb begin
    st_next      = st_reg;
    op_next      = op_reg;
    idx_next     = idx_reg;
    dev_req_next = '0;
    done_set     = 1'b0;
    fetch_set    = 1'b0;
    fetch_data   = dev_rdata;
    cur          = step_fn(op_reg, idx_reg, addr_reg, wdata_reg, ien_reg);
    poll_mask    = (op_reg == EEAC_OP_WRITE) ? CTL_WSTART : CTL_RSTART;
    unique case (st_reg)
      EEAC_ST_IDLE: begin
        if (start_cmd) begin
          op_next  = start_op;
          idx_next = IDX_RESET;
          st_next  = EEAC_ST_ISSUE;
        end
      end
      EEAC_ST_ISSUE: begin
        // one device access per cycle keeps permit and start adjacent
        dev_req_next = cur.req;
        if (cur.kind != EEAC_STEP_PUT) begin
          st_next = EEAC_ST_WAIT;
        end else if (cur.last) begin
          st_next  = EEAC_ST_IDLE;
          done_set = 1'b1;
        end else begin
          idx_next = idx_reg + 4'h1;
        end
      end
      EEAC_ST_WAIT: st_next = EEAC_ST_SAMPLE;
      EEAC_ST_SAMPLE: begin
        if (cur.kind == EEAC_STEP_POLL) begin
          // the device clears the start bit itself when the cycle ends
          if ((dev_rdata & poll_mask) == 8'h00) begin
            idx_next = idx_reg + 4'h1;
          end
          st_next = EEAC_ST_ISSUE;
        end else begin
          fetch_set = 1'b1;
          st_next   = EEAC_ST_IDLE;
          done_set  = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_reg      <= EEAC_ST_IDLE;
      op_reg      <= EEAC_OP_READ;
      idx_reg     <= IDX_RESET;
      dev_req_reg <= '0;
    end else begin
      st_reg      <= st_next;
      op_reg      <= op_next;
      idx_reg     <= idx_next;
      dev_req_reg <= dev_req_next;
    end
  end

endmodule : eeac_ctrl

// [eeac_ctrl_assertions.sv]
module eeac_ctrl_assertions
  import eeac_pkg::*;
(
  input wire logic                       clock,
  input wire logic                       rst,
  input wire eeac_pkg::eeac_apb_req_type apb_req,
  input wire eeac_pkg::eeac_apb_rsp_type apb_rsp,
  input wire eeac_pkg::eeac_dev_req_type dev_req,
  input wire logic [7:0]                 dev_rdata,
  input wire logic                       sleep_req
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);
  wire       rd   = dev_req.valid && !dev_req.write;
  wire       wr   = dev_req.valid && dev_req.write;
  wire [7:0] a    = dev_req.addr;
  wire [7:0] d    = dev_req.wdata;
  wire       iar  = wr && a == DEV_INDIRECT_ACCESS_REG_ADDR;
  wire       intc = wr && a == DEV_INTC_ADDR;
  wire       bp0  = wr && a == DEV_BP_ADDR && d == BP_BANK0;
  wire       bp1  = wr && a == DEV_BP_ADDR && d == BP_BANK1;
  wire       mp   = wr && a == DEV_MP1_ADDR && d == MP1_CTRL_VALUE;

  AST_ONE_WAIT: assert property (apb_req.psel && $rose(apb_req.penable) |-> !apb_rsp.pready ##1 apb_rsp.pready)
    else $error("pready not after one wait state");
  AST_READY_PULSE: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("pready longer than one cycle");
  AST_IDLE_QUIET: assert property (!apb_rsp.pready |-> apb_rsp.prdata == 32'h0 && !apb_rsp.pslverr)
    else $error("response fields without pready");
  AST_READ_GAP: assert property (rd |-> d == 8'h00 ##1 !dev_req.valid)
    else $error("device read not alone");
  AST_SLEEP_QUIET: assert property (sleep_req |-> !dev_req.valid)
    else $error("device access while sleep allowed");
  AST_START_NEXT: assert property (iar && d == CTL_WPERMIT |=> iar && d == (CTL_WPERMIT | CTL_WSTART))
    else $error("write start not next cycle");
  AST_GLOBAL_OFF: assert property (iar && d == CTL_WPERMIT |-> $past(intc && !d[INTC_GLOBAL_BIT]))
    else $error("global enable not cleared before write");
  AST_GLOBAL_ON: assert property (iar && d == (CTL_WPERMIT | CTL_WSTART) |=> intc && d[INTC_GLOBAL_BIT])
    else $error("global enable not restored");
  AST_BANK_OPEN: assert property (iar && d == CTL_RPERMIT |-> $past(bp1) && $past(mp, 2))
    else $error("control reached without pointers");
  AST_ADDR_RELOAD: assert property (iar && d == (CTL_RPERMIT | CTL_RSTART) |-> $past(wr && a == DEV_EEA_ADDR, 4))
    else $error("address not reloaded before read");
  AST_CLOSE_BANK: assert property (iar && d == CTL_CLEAR |=> bp0)
    else $error("bank not closed");
  AST_DATA_LAST: assert property (rd && a == DEV_EED_ADDR |-> $past(bp0))
    else $error("data taken before read end");
endmodule : eeac_ctrl_assertions

bind eeac_ctrl eeac_ctrl_assertions u_chk (.clock(clock), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .dev_req(dev_req), .dev_rdata(dev_rdata), .sleep_req(sleep_req));

// [eeac_dev_model.sv]
module eeac_dev_model
  import eeac_pkg::*;
#(
  parameter int   WR_TICKS   = 6,
  parameter int   RD_CYCLES  = 4,
  parameter logic STACK_FREE = 1'b1
) (
  input  wire logic                       clock,
  input  wire logic                       rst,
  input  wire eeac_pkg::eeac_dev_req_type dev_req,
  output logic [7:0]                      dev_rdata,
  input  wire logic                       sleep_req
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [NV_DEPTH];
  logic [7:0] eea, eed, mp1, bp, intc, eec, rv;
  logic       flag;
  logic       slow;
  logic [2:0] slow_s;
  int         wt, rt, n_service;
  wire        ctl_sel = mp1 == MP1_CTRL_VALUE && bp == BP_BANK1;
  wire  [7:0] wd      = dev_req.wdata;

  // write timer has its own oscillator, unrelated in phase to clock
  initial begin
    slow = 1'b0;
    forever #170 slow = ~slow;
  end

  always_comb begin
    case (dev_req.addr)
      DEV_EEA_ADDR:  rv = eea;
      DEV_EED_ADDR:  rv = eed;
      DEV_MP1_ADDR:  rv = mp1;
      DEV_BP_ADDR:   rv = bp;
      DEV_INTC_ADDR: rv = intc;
      DEV_INDIRECT_ACCESS_REG_ADDR: rv = ctl_sel ? eec : 8'h00;
      default:       rv = 8'h00;
    endcase
  end

  // outside a read the data line inverts every cycle, showing the last byte again every other cycle
  always @(posedge clock) begin
    slow_s <= {slow_s[1:0], slow};
    dev_rdata <= rd_now() ? rv : ~dev_rdata;
    if (rst) begin
      {eea, eed, mp1, bp, intc, eec} <= '0;
      flag <= 1'b0;
      wt <= 0;
      rt <= 0;
      n_service <= 0;
    end else begin
      if (dev_req.valid && dev_req.write) begin
        case (dev_req.addr)
          DEV_EEA_ADDR:  eea <= wd & 8'h1f;
          DEV_EED_ADDR:  eed <= wd;
          DEV_MP1_ADDR:  mp1 <= wd;
          DEV_BP_ADDR:   bp <= wd;
          DEV_INTC_ADDR: intc <= wd;
          DEV_INDIRECT_ACCESS_REG_ADDR: if (ctl_sel) eec <= {4'h0, wd[3], eec[2] | (wd[2] & eec[3]), wd[1], eec[0] | (wd[0] & eec[1])};
          default: ;
        endcase
      end
      if (eec[2] && slow_s[1] && !slow_s[2]) wt <= wt + 1;
      if (wt == WR_TICKS) begin
        mem[eea[4:0]] <= eed;
        eec[2] <= 1'b0;
        flag <= 1'b1;
        wt <= 0;
      end
      if (eec[0]) rt <= rt + 1;
      if (rt == RD_CYCLES) begin
        eed <= mem[eea[4:0]];
        eec[0] <= 1'b0;
        rt <= 0;
      end
      if (sleep_req && (eec[0] || eec[2])) begin
        eec[2] <= 1'b0;
        eec[0] <= 1'b0;
        wt <= 0;
        rt <= 0;
      end
      if (flag && intc[INTC_EEPROM_BIT] && intc[INTC_GLOBAL_BIT] && STACK_FREE) begin
        flag <= 1'b0;
        intc[INTC_GLOBAL_BIT] <= 1'b0;
        n_service <= n_service + 1;
      end
    end
  end

  function automatic logic rd_now();
    return dev_req.valid && !dev_req.write;
  endfunction : rd_now
endmodule : eeac_dev_model

// [eeprom_access_interrupt_ctrl_test.sv]
module eeprom_access_interrupt_ctrl_test import eeac_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] c_rd  = 32'h1 << CTRL_READ_BIT;
  localparam logic [31:0] c_wr  = 32'h1 << CTRL_WRITE_BIT;
  localparam logic [31:0] c_ien = 32'h1 << CTRL_IEN_BIT;
  localparam logic [31:0] c_slp = 32'h1 << CTRL_SLEEP_BIT;
  localparam logic [31:0] c_cfg = 32'h1 << CTRL_IRQCFG_BIT;
  logic             clock;
  logic             rst;
  logic             sleep_req;
  logic [7:0]       drd;
  logic [31:0]      q;
  logic             e;
  eeac_apb_req_type req;
  eeac_apb_rsp_type rsp;
  eeac_dev_req_type dreq;
  int               n_mismatch = 0;
  int               samples_checked = 0;

  eeac_ctrl dut (.clock(clock), .rst(rst), .apb_req(req), .apb_rsp(rsp), .dev_req(dreq),
    .dev_rdata(drd), .sleep_req(sleep_req));
  eeac_dev_model u_dev (.clock(clock), .rst(rst), .dev_req(dreq), .dev_rdata(drd), .sleep_req(sleep_req));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic end_sim;
    if (n_mismatch == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] y);
    samples_checked++;
    if (y !== x) begin
      $display("mismatch %s expected %h seen %h", nm, x, y);
      n_mismatch++;
    end
  endtask : chk

  // the request stands until the rising edge at which pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    req.psel   <= 1'b1;
    req.pwrite <= w;
    req.paddr  <= 32'(a);
    req.pwdata <= d;
    @(posedge clock);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (rsp.pready !== 1'b1 && n < 50);
    q = rsp.prdata;
    e = rsp.pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
    if (rsp.pready !== 1'b1) begin
      n_mismatch++;
      end_sim();
    end
  endtask : apb

  task automatic wait_done;
    int n;
    n = 0;
    do begin
      apb(1'b0, OFS_STATUS, 32'h0);
      n++;
    end while (q[ST_DONE_BIT] !== 1'b1 && n < 200);
    chk("done", 32'h1, 32'(q[ST_DONE_BIT]));
    if (q[ST_DONE_BIT] !== 1'b1)
      end_sim();
    apb(1'b1, OFS_STATUS, 32'h1 << ST_DONE_BIT);
  endtask : wait_done

  task automatic t_reset;
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("status", 32'h0, q);
    apb(1'b1, OFS_RDATA, 32'hff);
    apb(1'b0, OFS_RDATA, 32'h0);
    chk("rdata ro", 32'h0, q);
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped", 32'h1, {q[30:0], e});
  endtask : t_reset

  task automatic t_write(input logic [4:0] a, input logic [7:0] d, input logic ien);
    int sv;
    sv = u_dev.n_service;
    apb(1'b1, OFS_ADDR, 32'(a));
    apb(1'b1, OFS_WDATA, 32'(d));
    apb(1'b1, OFS_CTRL, c_wr | (ien ? c_ien : 32'h0));
    wait_done();
    chk("mem", 32'(d), 32'(u_dev.mem[a]));
    chk("control", 32'(CTL_CLEAR), 32'(u_dev.eec));
    chk("bank", 32'(BP_BANK0), 32'(u_dev.bp));
    chk("serviced", 32'(sv + ien), 32'(u_dev.n_service));
    chk("flag", 32'(!ien), 32'(u_dev.flag));
  endtask : t_write

  task automatic t_read(input logic [4:0] a, input logic [7:0] x);
    apb(1'b1, OFS_ADDR, 32'(a));
    apb(1'b1, OFS_CTRL, c_rd);
    wait_done();
    apb(1'b0, OFS_RDATA, 32'h0);
    chk("rdata", 32'(x), q);
    chk("bank", 32'(BP_BANK0), 32'(u_dev.bp));
  endtask : t_read

  task automatic t_irq;
    chk("pending", 32'h1, 32'(u_dev.flag));
    apb(1'b1, OFS_CTRL, c_cfg | c_ien);
    wait_done();
    chk("flag", 32'h0, 32'(u_dev.flag));
    chk("irq ctl", 32'h2, 32'(u_dev.intc));
  endtask : t_irq

  task automatic t_refuse;
    apb(1'b1, OFS_ADDR, 32'h5);
    apb(1'b1, OFS_CTRL, c_wr);
    apb(1'b1, OFS_ADDR, 32'h9);
    apb(1'b1, OFS_CTRL, c_slp);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("busy refused", 32'h5, q & 32'h7);
    chk("sleep busy", 32'h0, 32'(sleep_req));
    wait_done();
    apb(1'b0, OFS_ADDR, 32'h0);
    chk("addr held", 32'h5, q);
    chk("mem", 32'hc3, 32'(u_dev.mem[5]));
    apb(1'b1, OFS_STATUS, 32'h4);
    apb(1'b1, OFS_CTRL, c_slp);
    apb(1'b1, OFS_CTRL, c_slp | c_rd);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("sleep refused", 32'h4, q & 32'h7);
    chk("sleep", 32'h1, 32'(sleep_req));
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b1, OFS_STATUS, 32'h4);
  endtask : t_refuse

  initial begin
    rst = 1'b1;
    req = '0;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_write(5'h00, 8'ha5, 1'b1);
    t_write(5'h1f, 8'h5a, 1'b1);
    t_write(5'h1e, 8'hc3, 1'b0);
    t_read(5'h1e, 8'hc3);
    t_read(5'h1f, 8'h5a);
    t_read(5'h00, 8'ha5);
    t_irq();
    t_refuse();
    end_sim();
  end

  initial begin
    repeat (40000) @(posedge clock);
    n_mismatch++;
    end_sim();
  end
endmodule : eeprom_access_interrupt_ctrl_test
